/* File: dv/host_link_model.sv */
`timescale 1ns/1ps
module host_link_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // frame spacing in cycles less one, zero keeps the line silent
  input  wire logic [7:0] gap,
  // one pulse per frame handed to the drive
  output logic            valid_frame
);
  logic [7:0] cnt_q;

  // host polls the station every gap+1 cycles, a slow gap starves the watchdog
  always_ff @(posedge aclk) begin
    if (!aresetn || gap == 8'h00) begin
      cnt_q       <= 8'h00;
      valid_frame <= 1'b0;
    end else begin
      cnt_q       <= (cnt_q >= gap) ? 8'h00 : cnt_q + 8'h01;
      valid_frame <= (cnt_q >= gap);
    end
  end
endmodule // host_link_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import relay_ctl_pkg::*;
  typedef struct packed {logic [2:0] sel; logic [4:0] flt; logic [4:0] exp;} row_t;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0;
  logic [7:0]  awa = '0, ara = '0, temp = '0, gap = '0;
  logic [31:0] wd = '0, rdt, st;
  logic        awr, wr_r, bv, arr, rv, vf, make, brk, fan, lost, coast, decel, go, bt;
  logic [1:0]  br, rr;
  fault_in_t   faults = '0;
  logic [3:0]  aux = '0;
  logic [2:0]  oc = '0;
  logic        run = 0, pi = 1, seen;
  int          failures = 0, total_checks = 0, n;
  row_t rows[9] = '{'{3'h1, 5'h10, 5'h09}, '{3'h0, 5'h10, 5'h00}, '{3'h2, 5'h04, 5'h11},
                    '{3'h2, 5'h08, 5'h00}, '{3'h2, 5'h10, 5'h00}, '{3'h4, 5'h02, 5'h19},
                    '{3'h4, 5'h03, 5'h00}, '{3'h7, 5'h16, 5'h09}, '{3'h6, 5'h06, 5'h11}};

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  fault_relay_output_control #(.TENTH_CYCLES(10), .MS_CYCLES(4)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rq), .faults(faults), .auxiliary_contact(aux), .open_collector_out(oc),
    .drive_running(run), .drive_temp(temp), .pi_mode_on(pi), .valid_frame(vf),
    .relay_make_contact(make), .relay_break_contact(brk), .fan_on(fan),
    .lost_remote_indication(lost), .coast_to_rest_reaction(coast),
    .decel_stop_request(decel), .response_go(go), .baud_tick(bt));

  host_link_model host (.aclk(aclk), .aresetn(aresetn), .gap(gap), .valid_frame(vf));

  ////////////////////////////////////////////////////////////////////////////////
  // compare one result against its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // axi4-lite write, address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 0;
    dd = 0;
    awa <= a; wd <= d; awv <= 1; wv <= 1; bq <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && awr) begin ad = 1; awv <= 0; end
      if (!dd && wr_r) begin dd = 1; wv <= 0; end
    end
    do @(posedge aclk); while (!bv);
    chk(br, er);
  endtask

  // axi4-lite read, rready held until the answer is sampled
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    ara <= a; arv <= 1; rq <= 1;
    do @(posedge aclk); while (!arr);
    arv <= 0;
    do @(posedge aclk); while (!rv);
    d = rdt;
    chk(rr, er);
  endtask

  task automatic end_sim;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_sim();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    chk({make, brk, fan}, 3'b011);
    rd(8'h00, 2'b00, st); chk(st, 32'h2);
    rd(8'h08, 2'b00, st); chk(st, 32'h0);
    rd(8'h18, 2'b00, st); chk(st, 32'h0301);
    rd(8'h04, 2'b00, st); chk(st, 32'h0);
    rd(8'h40, 2'b10, st); chk(st, 32'h0);
    wr(8'h40, 32'h1, 2'b10);
    // selector table with zero delays
    foreach (rows[i]) begin
      wr(8'h00, {29'h0, rows[i].sel}, 2'b00);
      faults <= rows[i].flt;
      repeat (3) @(posedge aclk);
      rd(8'h24, 2'b00, st);
      chk(st & 32'h19, {27'h0, rows[i].exp});
      chk({make, brk}, {rows[i].exp[0], ~rows[i].exp[0]});
    end
    aux <= 4'ha; oc <= 3'h5;
    repeat (2) @(posedge aclk);
    rd(8'h04, 2'b00, st); chk(st, 32'hda);
    // on delay 3 tenths, off delay 2 tenths, then an early drop
    faults <= '0;
    wr(8'h00, 32'h2, 2'b00);
    wr(8'h08, 32'h3, 2'b00);
    wr(8'h0c, 32'h2, 2'b00);
    faults.general_fault <= 1;
    n = 0;
    while (!make && n < 100) begin @(posedge aclk); n++; end
    chk(n >= 20 && n <= 32, 1);
    faults.general_fault <= 0;
    n = 0;
    while (make && n < 100) begin @(posedge aclk); n++; end
    chk(n >= 10 && n <= 22, 1);
    faults.general_fault <= 1;
    repeat (15) @(posedge aclk);
    faults.general_fault <= 0;
    seen = 0;
    repeat (40) begin @(posedge aclk); seen |= make; end
    chk(seen, 0);
    // fan policies
    wr(8'h10, 32'h1, 2'b00); repeat (2) @(posedge aclk); chk(fan, 0);
    run <= 1; repeat (2) @(posedge aclk); chk(fan, 1);
    wr(8'h10, 32'h4002, 2'b00); temp <= 8'h40; repeat (2) @(posedge aclk); chk(fan, 0);
    temp <= 8'h41; repeat (2) @(posedge aclk); chk(fan, 1);
    // unit code, station and rate limits
    wr(8'h14, 32'h5, 2'b00); wr(8'h14, 32'h6, 2'b00);
    rd(8'h14, 2'b00, st); chk(st, 32'h5);
    pi <= 0; repeat (2) @(posedge aclk);
    rd(8'h14, 2'b00, st); chk(st, 32'h0);
    wr(8'h18, 32'h05fa, 2'b00); wr(8'h18, 32'h06fb, 2'b00);
    rd(8'h18, 2'b00, st); chk(st, 32'h05fa);
    // link loss under each reaction, timeout 5 ms
    for (int r = 0; r < 3; r++) begin
      wr(8'h1c, {16'h0005, 14'h0, 2'(r)}, 2'b00);
      gap <= 8'h08; repeat (40) @(posedge aclk);
      chk({lost, coast, decel}, 3'b000);
      gap <= 8'h00; repeat (40) @(posedge aclk);
      chk({lost, coast, decel}, {1'b1, r == 1, r == 2});
    end
    // response delay: 1 ms is refused, 3 ms kept, then timed from a lone frame
    wr(8'h20, 32'h1, 2'b00);
    wr(8'h20, 32'h3, 2'b00);
    rd(8'h20, 2'b00, st);
    chk(st, 32'h3);
    gap <= 8'h40;
    n = 0;
    while (!vf && n < 200) begin @(posedge aclk); n++; end
    n = 0;
    while (!go && n < 100) begin @(posedge aclk); n++; end
    chk(n >= 10 && n <= 13, 1);
    // bit period at code 5: 200 MHz / 38400 bit/s gives 5208 cycles
    n = 0;
    while (!bt && n < 6000) begin @(posedge aclk); n++; end
    n = 0;
    do begin @(posedge aclk); n++; end while (!bt && n < 6000);
    chk(n, 32'd5208);
    end_sim();
  end
endmodule // tb_top

/* File: verilog/fault_relay_output_control.sv */
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "relay_ctl_map.svh"
// Behaviour
// - undervoltage trip drives the relay only when the low-voltage select bit is set.
// - trip select bit lets every fault except undervoltage and external disable drive relay.
// - retry select drives relay when retry count hits zero, not while auto retry on.
// - simultaneous causes are ranked low-voltage, then trip, then retry.
// - relay is a changeover: make contact closes while break contact opens.
// - 8-bit snapshot: aux 1-4 in bits 0-3, open collectors 4-6, relay bit 7.
// - relay turn-on and turn-off are delayed by separate programmable times, default zero.
// - fan policy 0 keeps the fan on while powered; this is the default.
// - fan policy 1 runs the fan only while the drive outputs frequency.
// - fan policy 2 runs the fan when temperature exceeds the programmed threshold.
// - unit code 0 percent, 1 bar, 2 millibar, 3 kilopascal, 4 psi, 5 pascal.
// - process PI mode off forces the unit code back to percent.
// - station identifier is programmable 1 to 250, default 1.
// - bit rates 1200 to 38400 selected by code, default 9600.
// - no valid frame within the timeout declares link lost and shows lost-remote.
// - reaction none keeps running on link loss.
// - coast reaction disables the output immediately on link loss.
// - stop reaction requests a ramp down with the configured deceleration.
// - response delay on the serial link is programmable from 2 to 1200 ms.
module fault_relay_output_control
  import relay_ctl_pkg::*;
#(
  parameter int TENTH_CYCLES = `RELAY_STEP_MS * (`MS_PS / `CLK_PERIOD_PS),
  parameter int MS_CYCLES    = `MS_PS / `CLK_PERIOD_PS
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // drive state
  input  wire fault_in_t   faults,
  input  wire logic [3:0]  auxiliary_contact,
  input  wire logic [2:0]  open_collector_out,
  input  wire logic        drive_running,
  input  wire logic [7:0]  drive_temp,
  input  wire logic        pi_mode_on,
  // serial link events
  input  wire logic        valid_frame,
  // outputs
  output logic             relay_make_contact,
  output logic             relay_break_contact,
  output logic             fan_on,
  output logic             lost_remote_indication,
  output logic             coast_to_rest_reaction,
  output logic             decel_stop_request,
  output logic             response_go,
  output logic             baud_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // clock cycles per bit for each rate code
  function automatic logic [17:0] baud_div(input logic [2:0] code);
    case (code)
      3'h0:    baud_div = 18'(`BAUD_CLK_HZ / 1200);
      3'h1:    baud_div = 18'(`BAUD_CLK_HZ / 2400);
      3'h2:    baud_div = 18'(`BAUD_CLK_HZ / 4800);
      3'h3:    baud_div = 18'(`BAUD_CLK_HZ / 9600);
      3'h4:    baud_div = 18'(`BAUD_CLK_HZ / 19200);
      default: baud_div = 18'(`BAUD_CLK_HZ / 38400);
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `OFS_STATUS;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  cfg_t         cfg_q, cfg_d;
  logic         awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic [1:0]   bresp_q, bresp_d, rresp_q, rresp_d;
  logic         arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0]  rdata_q, rdata_d, wdata_q, wdata_d;
  logic [7:0]   awaddr_q, awaddr_d;
  logic [3:0]   wstrb_q, wstrb_d;
  logic         have_aw_q, have_aw_d, have_w_q, have_w_d;

  relay_state_t rly_q, rly_d;
  logic [15:0]  rly_cnt_q, rly_cnt_d;
  logic [1:0]   cause_q, cause_d;
  logic [31:0]  tenth_q, tenth_d, ms_q, ms_d;
  logic [15:0]  link_cnt_q, link_cnt_d;
  logic [10:0]  resp_cnt_q, resp_cnt_d;
  logic         resp_busy_q, resp_busy_d;
  logic [17:0]  baud_cnt_q, baud_cnt_d;
  logic [7:0]   snap_q, snap_d;
  logic         make_q, make_d, brk_q, brk_d, fan_q, fan_d, lost_q, lost_d;
  logic         coast_q, coast_d, decel_q, decel_d, go_q, go_d, btick_q, btick_d;
  logic         relay_req, tenth_tick, ms_tick;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave and register file

  // next bus and config values
  always_comb begin
    logic [31:0] w;
    w           = 32'h0;
    cfg_d       = cfg_q;
    awready_d   = awready_q;
    wready_d    = wready_q;
    bvalid_d    = bvalid_q;
    bresp_d     = bresp_q;
    arready_d   = arready_q;
    rvalid_d    = rvalid_q;
    rdata_d     = rdata_q;
    rresp_d     = rresp_q;
    awaddr_d    = awaddr_q;
    wdata_d     = wdata_q;
    wstrb_d     = wstrb_q;
    have_aw_d   = have_aw_q;
    have_w_d    = have_w_q;
    // address and data taken in either order
    if (s_axi_awvalid && awready_q) begin
      awaddr_d  = s_axi_awaddr;
      have_aw_d = 1'b1;
    end
    if (s_axi_wvalid && wready_q) begin
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
      have_w_d = 1'b1;
    end
    awready_d = !have_aw_d && !bvalid_q;
    wready_d  = !have_w_d && !bvalid_q;
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
    if (have_aw_q && have_w_q && !bvalid_q) begin
      have_aw_d = 1'b0;
      have_w_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(awaddr_q) ? 2'b00 : 2'b10;
      case (awaddr_q)
        `OFS_RELAY_SEL: begin
          w = merge({29'h0, cfg_q.relay_sel}, wdata_q, wstrb_q);
          cfg_d.relay_sel = w[2:0];
        end
        `OFS_ON_DELAY: begin
          w = merge({16'h0, cfg_q.on_delay}, wdata_q, wstrb_q);
          cfg_d.on_delay = w[15:0];
        end
        `OFS_OFF_DELAY: begin
          w = merge({16'h0, cfg_q.off_delay}, wdata_q, wstrb_q);
          cfg_d.off_delay = w[15:0];
        end
        `OFS_FAN_CTRL: begin
          w = merge({16'h0, cfg_q.fan_thresh, 6'h0, cfg_q.fan_policy}, wdata_q, wstrb_q);
          if (w[1:0] != 2'h3) cfg_d.fan_policy = fan_policy_t'(w[1:0]);
          cfg_d.fan_thresh = w[15:8];
        end
        `OFS_UNIT_SEL: begin
          w = merge({29'h0, cfg_q.unit_code}, wdata_q, wstrb_q);
          if (w[2:0] <= `UNIT_CODE_MAX) cfg_d.unit_code = w[2:0];
        end
        `OFS_STATION: begin
          w = merge({21'h0, cfg_q.baud_code, cfg_q.station_id}, wdata_q, wstrb_q);
          if (w[7:0] >= `STATION_MIN && w[7:0] <= `STATION_MAX)
            cfg_d.station_id = w[7:0];
          if (w[10:8] <= `BAUD_CODE_MAX) cfg_d.baud_code = w[10:8];
        end
        `OFS_LINK_CTRL: begin
          w = merge({cfg_q.timeout_ms, 14'h0, cfg_q.reaction}, wdata_q, wstrb_q);
          if (w[1:0] != 2'h3) cfg_d.reaction = reaction_t'(w[1:0]);
          cfg_d.timeout_ms = w[31:16];
        end
        `OFS_RESP_DELAY: begin
          w = merge({21'h0, cfg_q.resp_ms}, wdata_q, wstrb_q);
          if (w[10:0] >= `RESP_MS_MIN && w[10:0] <= `RESP_MS_MAX)
            cfg_d.resp_ms = w[10:0];
        end
        default: w = 32'h0;
      endcase
    end
    if (!pi_mode_on) cfg_d.unit_code = 3'h0; // percent forced
    // reads
    if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
    arready_d = !rvalid_d && !(s_axi_arvalid && arready_q);
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        `OFS_RELAY_SEL:  rdata_d = {29'h0, cfg_q.relay_sel};
        `OFS_OUT_SNAP:   rdata_d = {24'h0, snap_q};
        `OFS_ON_DELAY:   rdata_d = {16'h0, cfg_q.on_delay};
        `OFS_OFF_DELAY:  rdata_d = {16'h0, cfg_q.off_delay};
        `OFS_FAN_CTRL:   rdata_d = {16'h0, cfg_q.fan_thresh, 6'h0, cfg_q.fan_policy};
        `OFS_UNIT_SEL:   rdata_d = {29'h0, cfg_q.unit_code};
        `OFS_STATION:    rdata_d = {21'h0, cfg_q.baud_code, cfg_q.station_id};
        `OFS_LINK_CTRL:  rdata_d = {cfg_q.timeout_ms, 14'h0, cfg_q.reaction};
        `OFS_RESP_DELAY: rdata_d = {21'h0, cfg_q.resp_ms};
        `OFS_STATUS:     rdata_d = {27'h0, cause_q, fan_q, lost_q, make_q};
        default:         rdata_d = 32'h0;
      endcase
    end
  end

  // bus and config registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q      <= '{relay_sel: `RST_RELAY_SEL, on_delay: `RST_DELAY_TENTHS,
                      off_delay: `RST_DELAY_TENTHS, fan_policy: FAN_ALWAYS,
                      fan_thresh: `RST_FAN_THRESH, unit_code: 3'h0,
                      station_id: `RST_STATION_ID, baud_code: `RST_BAUD_CODE,
                      reaction: REACT_NONE, timeout_ms: `RST_TIMEOUT_MS,
                      resp_ms: `RST_RESP_MS};
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= 2'b00;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0;
      rresp_q    <= 2'b00;
      awaddr_q   <= 8'h0;
      wdata_q    <= 32'h0;
      wstrb_q    <= 4'h0;
      have_aw_q  <= 1'b0;
      have_w_q   <= 1'b0;
    end else begin
      cfg_q      <= cfg_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      have_aw_q  <= have_aw_d;
      have_w_q   <= have_w_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive-side logic

  assign tenth_tick = (tenth_q == 32'(TENTH_CYCLES - 1));
  assign ms_tick    = (ms_q == 32'(MS_CYCLES - 1));

  // next relay, fan, link and snapshot values
  always_comb begin
    tenth_d     = tenth_tick ? 32'h0 : tenth_q + 32'h1;
    ms_d        = ms_tick ? 32'h0 : ms_q + 32'h1;
    rly_d       = rly_q;
    rly_cnt_d   = rly_cnt_q;
    // cause ranked low-voltage, trip, retry
    if (cfg_q.relay_sel[`FLD_SEL_UV] && faults.undervoltage_trip)
      cause_d = 2'h1;
    else if (cfg_q.relay_sel[`FLD_SEL_TRIP] && faults.general_fault)
      cause_d = 2'h2; // external disable never counted
    else if (cfg_q.relay_sel[`FLD_SEL_RETRY] && faults.retry_count_zero
             && !faults.auto_retry_on)
      cause_d = 2'h3;
    else
      cause_d = 2'h0;
    relay_req = (cause_d != 2'h0);
    // delayed relay state machine, restarts on early change
    case (rly_q)
      RLY_OFF: if (relay_req) begin
        rly_d     = (cfg_q.on_delay == 16'h0) ? RLY_ON : RLY_ON_WAIT;
        rly_cnt_d = 16'h0;
      end
      RLY_ON_WAIT: begin
        if (!relay_req) rly_d = RLY_OFF;
        else if (tenth_tick) begin
          rly_cnt_d = rly_cnt_q + 16'h1;
          if (rly_cnt_q + 16'h1 >= cfg_q.on_delay) rly_d = RLY_ON;
        end
      end
      RLY_ON: if (!relay_req) begin
        rly_d     = (cfg_q.off_delay == 16'h0) ? RLY_OFF : RLY_OFF_WAIT;
        rly_cnt_d = 16'h0;
      end
      RLY_OFF_WAIT: begin
        if (relay_req) rly_d = RLY_ON;
        else if (tenth_tick) begin
          rly_cnt_d = rly_cnt_q + 16'h1;
          if (rly_cnt_q + 16'h1 >= cfg_q.off_delay) rly_d = RLY_OFF;
        end
      end
      default: rly_d = RLY_OFF;
    endcase
    make_d = (rly_d == RLY_ON) || (rly_d == RLY_OFF_WAIT);
    brk_d  = !make_d; // changeover pair
    snap_d = {make_d, open_collector_out, auxiliary_contact};
    // fan policy
    case (cfg_q.fan_policy)
      FAN_ALWAYS: fan_d = 1'b1;
      FAN_RUN:    fan_d = drive_running;
      FAN_TEMP:   fan_d = (drive_temp > cfg_q.fan_thresh);
      default:    fan_d = 1'b1;
    endcase
    // link watchdog in ms; a valid frame restarts it
    link_cnt_d = link_cnt_q;
    lost_d     = lost_q;
    if (valid_frame) begin
      link_cnt_d = 16'h0;
      lost_d     = 1'b0;
    end else if (ms_tick && !lost_q) begin
      link_cnt_d = link_cnt_q + 16'h1;
      if (link_cnt_q + 16'h1 >= cfg_q.timeout_ms) lost_d = 1'b1;
    end
    coast_d = lost_d && (cfg_q.reaction == REACT_COAST);
    decel_d = lost_d && (cfg_q.reaction == REACT_STOP);
    // answer delay after a received frame
    resp_cnt_d  = resp_cnt_q;
    resp_busy_d = resp_busy_q;
    go_d        = 1'b0;
    if (valid_frame) begin
      resp_busy_d = 1'b1;
      resp_cnt_d  = 11'h0;
    end else if (resp_busy_q && ms_tick) begin
      resp_cnt_d = resp_cnt_q + 11'h1;
      if (resp_cnt_q + 11'h1 >= cfg_q.resp_ms) begin
        resp_busy_d = 1'b0;
        go_d        = 1'b1;
      end
    end
    // bit-rate enable pulse
    btick_d    = (baud_cnt_q >= baud_div(cfg_q.baud_code) - 18'h1);
    baud_cnt_d = btick_d ? 18'h0 : baud_cnt_q + 18'h1;
  end

  // drive-side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tenth_q     <= 32'h0;
      ms_q        <= 32'h0;
      rly_q       <= RLY_OFF;
      rly_cnt_q   <= 16'h0;
      cause_q     <= 2'h0;
      make_q      <= 1'b0;
      brk_q       <= 1'b1;
      snap_q      <= 8'h00;
      fan_q       <= 1'b0;
      link_cnt_q  <= 16'h0;
      lost_q      <= 1'b0;
      coast_q     <= 1'b0;
      decel_q     <= 1'b0;
      resp_cnt_q  <= 11'h0;
      resp_busy_q <= 1'b0;
      go_q        <= 1'b0;
      baud_cnt_q  <= 18'h0;
      btick_q     <= 1'b0;
    end else begin
      tenth_q     <= tenth_d;
      ms_q        <= ms_d;
      rly_q       <= rly_d;
      rly_cnt_q   <= rly_cnt_d;
      cause_q     <= cause_d;
      make_q      <= make_d;
      brk_q       <= brk_d;
      snap_q      <= snap_d;
      fan_q       <= fan_d;
      link_cnt_q  <= link_cnt_d;
      lost_q      <= lost_d;
      coast_q     <= coast_d;
      decel_q     <= decel_d;
      resp_cnt_q  <= resp_cnt_d;
      resp_busy_q <= resp_busy_d;
      go_q        <= go_d;
      baud_cnt_q  <= baud_cnt_d;
      btick_q     <= btick_d;
    end
  end

  // outputs straight from flops
  assign s_axi_awready          = awready_q;
  assign s_axi_wready           = wready_q;
  assign s_axi_bvalid           = bvalid_q;
  assign s_axi_bresp            = bresp_q;
  assign s_axi_arready          = arready_q;
  assign s_axi_rvalid           = rvalid_q;
  assign s_axi_rdata            = rdata_q;
  assign s_axi_rresp            = rresp_q;
  assign relay_make_contact     = make_q;
  assign relay_break_contact    = brk_q;
  assign fan_on                 = fan_q;
  assign lost_remote_indication = lost_q;
  assign coast_to_rest_reaction = coast_q;
  assign decel_stop_request     = decel_q;
  assign response_go            = go_q;
  assign baud_tick              = btick_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  changeover_pair_a: assert property (make_q != brk_q)
    else $error("relay contacts not complementary");
  snap_relay_a: assert property (snap_q[`FLD_SNAP_RELAY] == make_q)
    else $error("snapshot relay bit differs from relay");
  uv_zero_delay_a: assert property (cfg_q.relay_sel == 3'h1 && cfg_q.on_delay == 16'h0
      && faults.undervoltage_trip && rly_q == RLY_OFF |=> make_q)
    else $error("undervoltage did not energise relay");
  ext_disable_only_a: assert property (faults == 5'b01000 && rly_q == RLY_OFF
      |=> !make_q)
    else $error("external disable energised relay");
  retry_auto_block_a: assert property (cfg_q.relay_sel == 3'h4 && faults.auto_retry_on
      |=> cause_q == 2'h0)
    else $error("retry cause active during auto retry");
  cause_priority_a: assert property (cfg_q.relay_sel[0] && faults.undervoltage_trip
      |=> cause_q == 2'h1)
    else $error("low voltage lost priority");
  fan_always_a: assert property (cfg_q.fan_policy == FAN_ALWAYS ##1
      cfg_q.fan_policy == FAN_ALWAYS |-> fan_q)
    else $error("fan off under always policy");
  unit_forced_a: assert property (!pi_mode_on |=> cfg_q.unit_code == 3'h0)
    else $error("unit not forced to percent");
  coast_on_loss_a: assert property (lost_q && cfg_q.reaction == REACT_COAST
      && $stable(cfg_q.reaction) && !valid_frame |=> coast_q)
    else $error("coast not applied on link loss");
  none_runs_a: assert property (cfg_q.reaction == REACT_NONE
      |=> !coast_q && !decel_q)
    else $error("reaction none altered drive");

endmodule // fault_relay_output_control

/* File: verilog/relay_ctl_map.svh */
`ifndef RELAY_CTL_MAP_SVH
`define RELAY_CTL_MAP_SVH
// register byte offsets
`define OFS_RELAY_SEL     8'h00
`define OFS_OUT_SNAP      8'h04
`define OFS_ON_DELAY      8'h08
`define OFS_OFF_DELAY     8'h0c
`define OFS_FAN_CTRL      8'h10
`define OFS_UNIT_SEL      8'h14
`define OFS_STATION       8'h18
`define OFS_LINK_CTRL     8'h1c
`define OFS_RESP_DELAY    8'h20
`define OFS_STATUS        8'h24
// reset values
`define RST_RELAY_SEL     3'h2
`define RST_DELAY_TENTHS  16'h0000
`define RST_FAN_POLICY    2'h0
`define RST_FAN_THRESH    8'h50
`define RST_STATION_ID    8'h01
`define RST_BAUD_CODE     3'h3
`define RST_TIMEOUT_MS    16'h03e8
`define RST_RESP_MS       11'h005
// field positions
`define FLD_SEL_UV        0
`define FLD_SEL_TRIP      1
`define FLD_SEL_RETRY     2
`define FLD_SNAP_RELAY    7
// limits
`define STATION_MIN       8'h01
`define STATION_MAX       8'hfa
`define BAUD_CODE_MAX     3'h5
`define UNIT_CODE_MAX     3'h5
`define RESP_MS_MIN       11'h002
`define RESP_MS_MAX       11'h4b0
// timing
`define CLK_PERIOD_PS     5000
`define RELAY_STEP_MS     100
`define MS_PS             1000000000
`define BAUD_CLK_HZ       200000000
`endif

/* File: verilog/relay_ctl_pkg.sv */
package relay_ctl_pkg;
  typedef enum logic [1:0] {FAN_ALWAYS, FAN_RUN, FAN_TEMP, FAN_RSVD} fan_policy_t;
  typedef enum logic [1:0] {REACT_NONE, REACT_COAST, REACT_STOP, REACT_RSVD} reaction_t;
  typedef enum {RLY_OFF, RLY_ON_WAIT, RLY_ON, RLY_OFF_WAIT} relay_state_t;
  // software configuration
  typedef struct packed {
    logic [2:0]  relay_sel;
    logic [15:0] on_delay;
    logic [15:0] off_delay;
    fan_policy_t fan_policy;
    logic [7:0]  fan_thresh;
    logic [2:0]  unit_code;
    logic [7:0]  station_id;
    logic [2:0]  baud_code;
    reaction_t   reaction;
    logic [15:0] timeout_ms;
    logic [10:0] resp_ms;
  } cfg_t;
  // drive-side fault inputs
  typedef struct packed {
    logic undervoltage_trip;
    logic external_disable_fault;
    logic general_fault;
    logic retry_count_zero;
    logic auto_retry_on;
  } fault_in_t;
endpackage
